// file: commutation_pkg.sv
// Shared constants and types for the commutation and Hall decode block.
// Assumes a single 50 MHz clock domain and no software-reachable registers.
package commutation_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int POS_W        = 16;
   localparam int STATE_W      = 8;
   localparam int PHASE_W      = 8;
   localparam int MAX_STATES   = 16;
   localparam int IDX_W        = 4;
   localparam int HALL_W       = 3;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [IDX_W-1:0]   STATE_NO_RST    = 4'h0;
   localparam logic [STATE_W-1:0] STATE_COUNT_RST = 8'h06;
   localparam logic [PHASE_W-1:0] PHASE_RST       = 8'h00;

   // ----------------------------------------------------------------------
   // Source of the commutation state
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_SENSORLESS_MATCH,
      SRC_SENSORLESS_LINK,
      SRC_HALL
   } state_source_e;

endpackage

// file: motor_commutation_hall_decode.sv
// Commutation state machine with Hall-sensor decode and sensorless position input.
// Assumes all inputs are synchronous to clk; pattern table is loaded through a write port.
//
// Behaviour
// - Drive phase commutation outputs for brushless motors.
// - Sensorless state derived from quadrature position count.
// - Configurable state sequence and output patterns.
// - Offset writable anytime, shifts angles without stopping.
// - Hall levels plus direction bit form state.
// - Two or three sensor decoding selectable.
// - Hall state written into channel, outputs follow.
`timescale 1ns/1ps
module motor_commutation_hall_decode (
   // Clock and reset
   input  wire logic                                     clk,
   input  wire logic                                     arst_n,
   // Configuration
   input  wire commutation_pkg::state_source_e           state_source,
   input  wire logic [commutation_pkg::STATE_W-1:0]      state_count,
   input  wire logic [commutation_pkg::POS_W-1:0]        counts_per_state,
   input  wire logic signed [commutation_pkg::POS_W-1:0] angle_offset,
   input  wire logic                                     three_sensor_mode,
   input  wire logic                                     cpu_direction,
   // Pattern table load
   input  wire logic                                     pattern_we,
   input  wire logic [commutation_pkg::IDX_W-1:0]        pattern_addr,
   input  wire logic [commutation_pkg::PHASE_W-1:0]      pattern_data,
   // Force state
   input  wire logic                                     force_state,
   input  wire logic [commutation_pkg::IDX_W-1:0]        force_index,
   // Position and sensors
   input  wire logic [commutation_pkg::POS_W-1:0]        position_count,
   input  wire logic                                     position_update,
   input  wire logic [commutation_pkg::HALL_W-1:0]       hall_in,
   // Outputs
   output logic      [commutation_pkg::IDX_W-1:0]        state_no,
   output logic      [commutation_pkg::PHASE_W-1:0]      phase_out
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Wraps a candidate index into 0..count-1; a zero count is treated as one.
   function automatic logic [commutation_pkg::IDX_W-1:0] wrap_idx(
      input logic [commutation_pkg::STATE_W:0]   idx,
      input logic [commutation_pkg::STATE_W-1:0] cnt);
      logic [commutation_pkg::STATE_W:0] c;
      logic [commutation_pkg::STATE_W:0] r;
      c = (cnt == 8'h00) ? 9'h001 : {1'b0, cnt};
      r = idx % c;
      return r[commutation_pkg::IDX_W-1:0];
   endfunction

   logic [commutation_pkg::PHASE_W-1:0] pattern_mem [commutation_pkg::MAX_STATES];
   logic [commutation_pkg::IDX_W-1:0]   state_q;
   logic [commutation_pkg::IDX_W-1:0]   state_d;
   logic [commutation_pkg::PHASE_W-1:0] phase_q;
   logic [commutation_pkg::IDX_W-1:0]   hall_state;
   logic [commutation_pkg::IDX_W-1:0]   sensorless_state;

   // ----------------------------------------------------------------------
   // Pattern table
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (pattern_we) begin
         pattern_mem[pattern_addr] <= pattern_data;
      end
   end

   // ----------------------------------------------------------------------
   // Sensorless position to state
   // ----------------------------------------------------------------------
   // The offset is added to every position sample, so a change shifts all
   // switching angles at the next update without halting the sequence.
   logic [commutation_pkg::POS_W-1:0]   shifted_pos;
   logic [commutation_pkg::POS_W-1:0]   cps;
   logic [commutation_pkg::POS_W-1:0]   sector;
   always_comb begin
      shifted_pos = position_count + angle_offset;
      cps         = (counts_per_state == 16'h0000) ? 16'h0001 : counts_per_state;
      sector      = shifted_pos / cps;
      sensorless_state = wrap_idx({1'b0, sector[commutation_pkg::STATE_W-1:0]}, state_count);
   end

   // ----------------------------------------------------------------------
   // Hall decode
   // ----------------------------------------------------------------------
   // Direction forms the top bit of the raw code; two-sensor mode ignores the third input.
   logic [commutation_pkg::STATE_W:0] hall_raw;
   always_comb begin
      if (three_sensor_mode) begin
         hall_raw = {5'h00, cpu_direction, hall_in};
      end else begin
         hall_raw = {6'h00, cpu_direction, hall_in[1:0]};
      end
      hall_state = wrap_idx(hall_raw, state_count);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // A held index is wrapped as well, so a smaller state count cannot strand the
   // index outside the sequence until the next position update.
   always_comb begin
      state_d = wrap_idx({5'h00, state_q}, state_count);
      if (force_state) begin
         state_d = wrap_idx({5'h00, force_index}, state_count);
      end else begin
         unique case (state_source)
            commutation_pkg::SRC_HALL: begin
               state_d = hall_state;
            end
            commutation_pkg::SRC_SENSORLESS_MATCH,
            commutation_pkg::SRC_SENSORLESS_LINK: begin
               if (position_update) begin
                  state_d = sensorless_state;
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= commutation_pkg::STATE_NO_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------------
   // Phase drive
   // ----------------------------------------------------------------------
   // The pattern is registered one cycle after the state so outputs stay glitch free.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= commutation_pkg::PHASE_RST;
      end else begin
         phase_q <= pattern_mem[state_q];
      end
   end

   assign state_no  = state_q;
   assign phase_out = phase_q;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_wrap;
      @(posedge clk) disable iff (!arst_n)
      // The index may sit outside the range for the one edge at which the count shrinks.
      (state_count != 8'h00 && $stable(state_count)) |-> ({4'h0, state_q} < state_count);
   endproperty
   a_wrap: assert property (p_wrap) else $error("state index outside state count");

   property p_phase_follows;
      @(posedge clk) disable iff (!arst_n)
      !pattern_we |=> (phase_q == pattern_mem[$past(state_q)]);
   endproperty
   a_phase_follows: assert property (p_phase_follows) else $error("phase output does not match state");

   property p_hall_load;
      @(posedge clk) disable iff (!arst_n)
      (!force_state && state_source == commutation_pkg::SRC_HALL) |=> (state_q == $past(hall_state));
   endproperty
   a_hall_load: assert property (p_hall_load) else $error("hall state not loaded");

   property p_hall_dir;
      @(posedge clk) disable iff (!arst_n)
      (state_count == 8'h10 && three_sensor_mode) |-> (hall_state == {cpu_direction, hall_in});
   endproperty
   a_hall_dir: assert property (p_hall_dir) else $error("hall decode wrong");

   property p_two_sensor;
      @(posedge clk) disable iff (!arst_n)
      (state_count == 8'h10 && !three_sensor_mode) |-> (hall_state[3:2] == {1'b0, cpu_direction});
   endproperty
   a_two_sensor: assert property (p_two_sensor) else $error("two sensor decode wrong");

   property p_sensorless_hold;
      @(posedge clk) disable iff (!arst_n)
      (!force_state && state_source != commutation_pkg::SRC_HALL && !position_update && $stable(state_count))
         |=> $stable(state_q);
   endproperty
   a_sensorless_hold: assert property (p_sensorless_hold) else $error("state moved without update");

   property p_sensorless_load;
      @(posedge clk) disable iff (!arst_n)
      (!force_state && state_source != commutation_pkg::SRC_HALL && position_update)
         |=> (state_q == $past(sensorless_state));
   endproperty
   a_sensorless_load: assert property (p_sensorless_load) else $error("offset position not applied");

   property p_force;
      @(posedge clk) disable iff (!arst_n)
      (force_state && {4'h0, force_index} < state_count) |=> (state_q == $past(force_index));
   endproperty
   a_force: assert property (p_force) else $error("forced state not taken");

   // A Hall code taken at one edge reaches the phase pins two edges later.
   sequence s_hall_taken;
      !force_state && state_source == commutation_pkg::SRC_HALL && !pattern_we;
   endsequence
   property p_hall_to_phase;
      @(posedge clk) disable iff (!arst_n)
      s_hall_taken ##1 !pattern_we |=> (phase_q == pattern_mem[$past(hall_state, 2)]);
   endproperty
   a_hall_to_phase: assert property (p_hall_to_phase) else $error("phase output does not follow hall code");

   // A position update reaches the phase pins two edges later.
   sequence s_position_taken;
      !force_state && state_source != commutation_pkg::SRC_HALL && position_update;
   endsequence
   property p_position_to_phase;
      @(posedge clk) disable iff (!arst_n)
      s_position_taken ##1 !pattern_we |=> (phase_q == pattern_mem[$past(sensorless_state, 2)]);
   endproperty
   a_position_to_phase: assert property (p_position_to_phase) else $error("phase output does not follow position");

endmodule // motor_commutation_hall_decode

// file: motor_sensor_model.sv
// Behavioural model of the motor position encoder and Hall sensors.
// Assumes the bench requests a move with a one-cycle pulse launched at a falling edge.
`timescale 1ns/1ps
module motor_sensor_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Move request from the bench
   input  wire logic        move,
   input  wire logic [15:0] new_pos,
   input  wire logic [2:0]  new_hall,
   // Sensor side
   output logic      [15:0] position_count,
   output logic             position_update,
   output logic      [2:0]  hall_in
);
   logic req_q;

   // The request is taken on a rising edge and shown at the next falling edge, so the
   // count and its strobe change together, half a cycle before the design samples them.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) req_q <= 1'b0;
      else req_q <= move;
   end

   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         position_count  <= 16'h0000;
         position_update <= 1'b0;
         hall_in         <= 3'h0;
      end else begin
         position_update <= req_q;
         if (req_q) begin
            position_count <= new_pos;
            hall_in        <= new_hall;
         end
      end
   end
endmodule // motor_sensor_model

// file: tb_motor_commutation_hall_decode.sv
// Self-checking bench for the commutation block with Hall and sensorless sources.
// Assumes the sensor model sits on the far side; all inputs change on falling edges.
`timescale 1ns/1ps
module tb_motor_commutation_hall_decode;
   logic clk = 1'b0, arst_n = 1'b0, mv = 1'b0, tsm = 1'b1, dir = 1'b0, pwe = 1'b0, frc = 1'b0;
   logic [3:0] paddr = 4'h0, fidx = 4'h0, st;
   logic [7:0] pdata = 8'h00, cnt = 8'h10, ph;
   logic [15:0] cps = 16'h0004, npos = 16'h0000, pos;
   logic signed [15:0] offs = 16'sh0000;
   logic [2:0] nhall = 3'h0, hall;
   logic upd;
   commutation_pkg::state_source_e src = commutation_pkg::SRC_HALL;
   int bad_count = 0, n_checks = 0, cycles = 0;

   motor_sensor_model u_motor_sensor_model (.clk(clk), .arst_n(arst_n), .move(mv), .new_pos(npos),
      .new_hall(nhall), .position_count(pos), .position_update(upd), .hall_in(hall));
   motor_commutation_hall_decode u_motor_commutation_hall_decode (.clk(clk), .arst_n(arst_n),
      .state_source(src), .state_count(cnt), .counts_per_state(cps), .angle_offset(offs),
      .three_sensor_mode(tsm), .cpu_direction(dir), .pattern_we(pwe), .pattern_addr(paddr),
      .pattern_data(pdata), .force_state(frc), .force_index(fidx), .position_count(pos),
      .position_update(upd), .hall_in(hall), .state_no(st), .phase_out(ph));

   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Each index gets a pattern with distinct nibbles so a wrong index cannot alias.
   task automatic expect_state(input logic [3:0] idx);
      repeat (3) @(negedge clk);
      check({4'h0, st}, {4'h0, idx});
      check(ph, {~idx, idx});
   endtask

   task automatic sense(input logic [15:0] p, input logic [2:0] h);
      mv = 1'b1; npos = p; nhall = h;
      @(negedge clk) mv = 1'b0;
   endtask

   task automatic hall_sweep();
      src = commutation_pkg::SRC_HALL; cnt = 8'h10; tsm = 1'b1;
      for (int d = 0; d < 2; d++) for (int h = 0; h < 8; h++) begin
         dir = d[0]; sense(16'h0000, h[2:0]);
         expect_state({d[0], h[2:0]});
      end
      cnt = 8'h06; tsm = 1'b0; dir = 1'b1; sense(16'h0000, 3'h7);
      expect_state(4'h1);
      tsm = 1'b1; dir = 1'b0; sense(16'h0000, 3'h3);
      expect_state(4'h3);
   endtask

   task automatic sensorless(input commutation_pkg::state_source_e s);
      src = s; cnt = 8'h06; offs = 16'sh0000; sense(16'h0008, 3'h0);
      expect_state(4'h2);
      // An offset change alone must not move the state until the next position update.
      offs = 16'sh0010; npos = 16'h0064; repeat (4) @(negedge clk);
      check({4'h0, st}, 8'h02);
      offs = 16'sh0000; sense(16'h001C, 3'h0);
      expect_state(4'h1);
      offs = -16'sh0014; sense(16'h001C, 3'h0);
      expect_state(4'h2);
      offs = 16'sh0004; sense(16'h0008, 3'h0);
      expect_state(4'h3);
   endtask

   task automatic forcing();
      cnt = 8'h06; fidx = 4'h9; frc = 1'b1;
      @(negedge clk) frc = 1'b0;
      expect_state(4'h3);
      fidx = 4'h4; frc = 1'b1;
      @(negedge clk) frc = 1'b0;
      expect_state(4'h4);
      cnt = 8'h03;
      expect_state(4'h1);
   endtask

   initial begin
      repeat (2) @(negedge clk);
      check({4'h0, st}, 8'h00);
      check(ph, 8'h00);
      arst_n = 1'b1;
      for (int i = 0; i < 16; i++) begin
         pwe = 1'b1; paddr = i[3:0]; pdata = {~i[3:0], i[3:0]};
         @(negedge clk);
      end
      pwe = 1'b0;
      hall_sweep();
      sensorless(commutation_pkg::SRC_SENSORLESS_MATCH);
      sensorless(commutation_pkg::SRC_SENSORLESS_LINK);
      forcing();
      report_and_stop();
   end
endmodule // tb_motor_commutation_hall_decode
